// ===== hw/otn_port_encryption_framer.sv
// port modes, esp overhead framing and register file of the encrypting otn card
`timescale 1ns/100ps
`include "otn_enc_consts.svh"
module otn_port_encryption_framer
  import otn_enc_pkg::*;
#(
  parameter int NUM_PORTS = `NUM_PORT_PAIRS,
  parameter int MAX_TXP = `MAX_TXP_PORTS,
  parameter int TICK_CYCLES = `REKEY_TICK_US * 1000 / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // key exchange engine
  input wire logic [NUM_PORTS-1:0] kx_done,
  input wire logic [NUM_PORTS-1:0] kx_fail,
  output logic [NUM_PORTS-1:0] kx_start,
  // trunk condition
  input wire logic [NUM_PORTS-1:0] trunk_ais,
  // transmit overhead
  input wire logic [NUM_PORTS-1:0] tx_frame_start,
  input wire esp_block_t [NUM_PORTS-1:0] tx_esp,
  output oh_pair_t [NUM_PORTS-1:0] tx_oh,
  output logic [NUM_PORTS-1:0] tx_oh_a_en,
  output logic [NUM_PORTS-1:0] tx_oh_b_en,
  output logic [NUM_PORTS-1:0] tx_pkt_start,
  // receive overhead
  input wire logic [NUM_PORTS-1:0] rx_frame_start,
  input wire logic [NUM_PORTS-1:0] rx_pkt_first,
  input wire oh_pair_t [NUM_PORTS-1:0] rx_oh,
  output esp_block_t [NUM_PORTS-1:0] rx_esp,
  output logic [NUM_PORTS-1:0] rx_esp_valid,
  // port control
  output port_mode_t [NUM_PORTS-1:0] port_mode,
  output wrapper_t [NUM_PORTS-1:0] trunk_wrapper,
  output logic [NUM_PORTS-1:0] otn_enable,
  output logic [NUM_PORTS-1:0] cipher_enable,
  output logic [NUM_PORTS-1:0] key_epoch,
  output logic [NUM_PORTS-1:0] key_exchange_failure_alarm
);
  port_cfg_t cfg [NUM_PORTS];
  port_cfg_t wcfg;
  logic [`TXP_CNT_W-1:0] txp_count;
  logic [NUM_PORTS-1:0] wr_cfg;
  logic [NUM_PORTS-1:0] wr_stat;
  logic [NUM_PORTS-1:0] wr_cmd;
  logic [NUM_PORTS-1:0] refuse;
  logic [NUM_PORTS-1:0] refused;
  logic [NUM_PORTS-1:0] prbs_err;
  logic [NUM_PORTS-1:0] prbs_bad;
  logic [NUM_PORTS-1:0] rekey;
  logic [NUM_PORTS-1:0] auth_en;
  logic [NUM_PORTS-1:0] authenticated;
  logic [NUM_PORTS-1:0] rx_primed;
  logic [2:0] tx_idx [NUM_PORTS];
  logic [2:0] rx_idx [NUM_PORTS];
  logic [31:0] prbs_tx [NUM_PORTS];
  logic [31:0] prbs_rx [NUM_PORTS];
  esp_block_t rx_buf [NUM_PORTS];
  logic soft_reset;
  logic wr_ctrl;
  logic wr_period;
  logic [`PERIOD_W-1:0] rekey_period;
  logic [`PERIOD_W-1:0] period_cnt;
  logic [31:0] tick_cnt;
  logic rekey_all;

  function automatic wrapper_t map_wrapper(payload_t pl);
    unique case (pl)
      pl_10ge_cbr, pl_otu2e: return wrap_otu2e;
      pl_otu2, pl_fc8, pl_fc10, pl_10ge_gfp: return wrap_otu2;
      pl_otu1e: return wrap_otu1e;
      default: return wrap_none;
    endcase
  endfunction

  function automatic logic is_otu(payload_t pl);
    return pl == pl_otu1e || pl == pl_otu2 || pl == pl_otu2e;
  endfunction

  // next 32 bits of x^31+x^28+1 following a word
  function automatic logic [31:0] prbs_next(logic [31:0] w);
    logic [30:0] s;
    logic [31:0] o;
    logic b;
    s = w[30:0];
    o = '0;
    for (int k = 0; k < `PRBS_WORD; k++) begin
      b = s[`PRBS_TAP_A] ^ s[`PRBS_TAP_B];
      s = {s[29:0], b};
      o = {o[30:0], b};
    end
    return o;
  endfunction

  // esp bytes of frame i, byte 0 first, header before trailer
  function automatic oh_pair_t esp_slice(esp_block_t e, logic f8, logic sel, logic [2:0] i);
    oh_pair_t o;
    logic [1:0] w;
    logic [2:0] h;
    logic [31:0] q;
    o = '0;
    w = ~i[1:0];
    h = ~i;
    q = {e.hdr[{h, 4'h0} +: 16], e.trl[{h, 4'h0} +: 16]};
    if (!f8) begin
      o.loc_a = e.hdr[{w, 5'h00} +: 32];
      o.loc_b = e.trl[{w, 5'h00} +: 32];
    end else if (sel) begin
      o.loc_b = q;
    end else begin
      o.loc_a = q;
    end
    return o;
  endfunction

  // register decode and write checks
  assign wcfg = port_cfg_t'(reg_wdata[`CFG_WIDTH-1:0]);
  assign wr_ctrl = reg_wr && !`REG_HI(reg_addr) && `REG_PORT(reg_addr) == `GLOBAL_PORT
    && `REG_SUB(reg_addr) == `SUB_CARD_CTRL;
  assign wr_period = reg_wr && !`REG_HI(reg_addr) && `REG_PORT(reg_addr) == `GLOBAL_PORT
    && `REG_SUB(reg_addr) == `SUB_REKEY_PERIOD;

  always_comb begin
    txp_count = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (cfg[p].mode == single_stream_transponder_mode) txp_count = txp_count + 1'b1;
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr_cfg[p] = reg_wr && !`REG_HI(reg_addr) && `REG_PORT(reg_addr) == 3'(p)
        && `REG_SUB(reg_addr) == `SUB_CFG;
      wr_stat[p] = reg_wr && !`REG_HI(reg_addr) && `REG_PORT(reg_addr) == 3'(p)
        && `REG_SUB(reg_addr) == `SUB_STATUS;
      wr_cmd[p] = reg_wr && !`REG_HI(reg_addr) && `REG_PORT(reg_addr) == 3'(p)
        && `REG_SUB(reg_addr) == `SUB_CMD;
      refuse[p] = 1'b0;
      if (wcfg.mode == port_mode_t'(`MODE_ILLEGAL) || wcfg.payload == payload_t'(`PAYLOAD_ILLEGAL))
        refuse[p] = 1'b1;
      if (wcfg.mode == single_stream_transponder_mode
          && cfg[p].mode != single_stream_transponder_mode
          && txp_count >= `TXP_CNT_W'(MAX_TXP)) refuse[p] = 1'b1;
      if (wcfg.mode == regenerator_mode && !is_otu(wcfg.payload)) refuse[p] = 1'b1;
      if (wcfg.mode != single_stream_transponder_mode && (wcfg.auth || wcfg.enc))
        refuse[p] = 1'b1;
      if (wcfg.enc && !wcfg.auth) refuse[p] = 1'b1;
      auth_en[p] = cfg[p].mode == single_stream_transponder_mode && cfg[p].auth;
    end
  end

  // per-port configuration, nothing provisioned after reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NUM_PORTS; p++) cfg[p] <= port_cfg_t'(`CFG_RESET);
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wr_cfg[p] && !refuse[p]) cfg[p] <= wcfg;
      end
    end
  end

  // sticky flags, a new event beats a clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      refused <= '0;
      prbs_err <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wr_cfg[p] && refuse[p]) refused[p] <= 1'b1;
        else if (wr_stat[p] && reg_wdata[`STAT_REFUSED_BIT]) refused[p] <= 1'b0;
        if (prbs_bad[p]) prbs_err[p] <= 1'b1;
        else if (wr_stat[p] && reg_wdata[`STAT_PRBS_ERR_BIT]) prbs_err[p] <= 1'b0;
      end
    end
  end

  // card control, rekey period and tick
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      soft_reset <= 1'b0;
      rekey_period <= '0;
      rekey <= '0;
    end else begin
      soft_reset <= wr_ctrl && reg_wdata[`CTRL_SOFT_RESET_BIT];
      if (wr_period) rekey_period <= reg_wdata[`PERIOD_W-1:0];
      for (int p = 0; p < NUM_PORTS; p++) begin
        rekey[p] <= (wr_cmd[p] && reg_wdata[`CMD_REKEY_BIT]) || rekey_all;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= '0;
      period_cnt <= '0;
      rekey_all <= 1'b0;
    end else begin
      rekey_all <= 1'b0;
      if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
        if (rekey_period == '0 || period_cnt >= rekey_period - 1'b1) begin
          period_cnt <= '0;
          rekey_all <= rekey_period != '0;
        end else begin
          period_cnt <= period_cnt + 1'b1;
        end
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  // register read, data valid in the following cycle only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd && !`REG_HI(reg_addr)) begin
        if (`REG_PORT(reg_addr) == `GLOBAL_PORT) begin
          if (`REG_SUB(reg_addr) == `SUB_CARD_STATUS) reg_rdata <= 32'(txp_count);
          if (`REG_SUB(reg_addr) == `SUB_REKEY_PERIOD) reg_rdata <= 32'(rekey_period);
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (`REG_PORT(reg_addr) == 3'(p) && `REG_SUB(reg_addr) == `SUB_CFG)
            reg_rdata <= 32'(cfg[p]);
          if (`REG_PORT(reg_addr) == 3'(p) && `REG_SUB(reg_addr) == `SUB_STATUS)
            reg_rdata <= 32'({refused[p], trunk_wrapper[p], 1'b0, prbs_err[p], key_epoch[p],
              cipher_enable[p], key_exchange_failure_alarm[p], authenticated[p]});
        end
      end
    end
  end

  // mode-derived port controls
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_mode <= '{default: mode_off};
      trunk_wrapper <= '{default: wrap_none};
      otn_enable <= '0;
      cipher_enable <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_mode[p] <= cfg[p].mode;
        trunk_wrapper[p] <= cfg[p].mode == mode_off ? wrap_none : map_wrapper(cfg[p].payload);
        otn_enable[p] <= cfg[p].mode != mode_off;
        cipher_enable[p] <= auth_en[p] && cfg[p].enc && authenticated[p];
      end
    end
  end

  // transmit esp overhead and prbs pattern
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        tx_idx[p] <= '0;
        prbs_tx[p] <= `PRBS_SEED;
      end
      tx_oh <= '0;
      tx_oh_a_en <= '0;
      tx_oh_b_en <= '0;
      tx_pkt_start <= '0;
    end else begin
      tx_pkt_start <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (tx_frame_start[p]) begin
          tx_pkt_start[p] <= tx_idx[p] == '0;
          if (cfg[p].mode != single_stream_transponder_mode
              || tx_idx[p] == (cfg[p].frames8 ? `FRAMES_LONG : `FRAMES_SHORT))
            tx_idx[p] <= '0;
          else
            tx_idx[p] <= tx_idx[p] + 1'b1;
          tx_oh_a_en[p] <= auth_en[p] && (cfg[p].enc || cfg[p].prbs)
            && (!cfg[p].frames8 || !cfg[p].oh_sel);
          tx_oh_b_en[p] <= auth_en[p] && (cfg[p].enc || cfg[p].prbs)
            && (!cfg[p].frames8 || cfg[p].oh_sel);
          if (cfg[p].prbs) begin
            if (!cfg[p].frames8) begin
              tx_oh[p] <= {prbs_tx[p], prbs_next(prbs_tx[p])};
              prbs_tx[p] <= prbs_next(prbs_next(prbs_tx[p]));
            end else begin
              tx_oh[p] <= {prbs_tx[p], prbs_tx[p]};
              prbs_tx[p] <= prbs_next(prbs_tx[p]);
            end
          end else if (cfg[p].enc) begin
            tx_oh[p] <= esp_slice(tx_esp[p], cfg[p].frames8, cfg[p].oh_sel, tx_idx[p]);
          end else begin
            tx_oh[p] <= '0;
          end
        end
      end
    end
  end

  // receive esp reassembly and prbs check
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      prbs_bad[p] = 1'b0;
      if (rx_frame_start[p] && cfg[p].prbs && auth_en[p]) begin
        if (!cfg[p].frames8)
          prbs_bad[p] = (rx_primed[p] && rx_oh[p].loc_a != prbs_next(prbs_rx[p]))
            || rx_oh[p].loc_b != prbs_next(rx_oh[p].loc_a);
        else
          prbs_bad[p] = rx_primed[p] && prbs_next(prbs_rx[p])
            != (cfg[p].oh_sel ? rx_oh[p].loc_b : rx_oh[p].loc_a);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        rx_idx[p] <= '0;
        prbs_rx[p] <= '0;
        rx_buf[p] <= '0;
      end
      rx_primed <= '0;
      rx_esp <= '0;
      rx_esp_valid <= '0;
    end else begin
      rx_esp_valid <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!cfg[p].prbs || !auth_en[p]) rx_primed[p] <= 1'b0;
        if (rx_frame_start[p] && auth_en[p]) begin
          rx_idx[p] <= rx_pkt_first[p] ? 3'h0 : rx_idx[p] + 1'b1;
          if (cfg[p].prbs) begin
            rx_primed[p] <= 1'b1;
            prbs_rx[p] <= cfg[p].frames8 && !cfg[p].oh_sel ? rx_oh[p].loc_a : rx_oh[p].loc_b;
          end else if (cfg[p].enc) begin
            if (!cfg[p].frames8) begin
              rx_buf[p].hdr[{~rx_next(rx_pkt_first[p], rx_idx[p]), 5'h00} +: 32]
                <= rx_oh[p].loc_a;
              rx_buf[p].trl[{~rx_next(rx_pkt_first[p], rx_idx[p]), 5'h00} +: 32]
                <= rx_oh[p].loc_b;
            end else begin
              rx_buf[p].hdr[{~rx_sel3(rx_pkt_first[p], rx_idx[p]), 4'h0} +: 16]
                <= cfg[p].oh_sel ? rx_oh[p].loc_b[31:16] : rx_oh[p].loc_a[31:16];
              rx_buf[p].trl[{~rx_sel3(rx_pkt_first[p], rx_idx[p]), 4'h0} +: 16]
                <= cfg[p].oh_sel ? rx_oh[p].loc_b[15:0] : rx_oh[p].loc_a[15:0];
            end
            if (rx_sel3(rx_pkt_first[p], rx_idx[p])
                == (cfg[p].frames8 ? `FRAMES_LONG : `FRAMES_SHORT)) begin
              rx_esp[p] <= rx_merge(rx_buf[p], rx_oh[p], cfg[p].frames8, cfg[p].oh_sel);
              rx_esp_valid[p] <= 1'b1;
            end
          end
        end
      end
    end
  end

  function automatic logic [2:0] rx_sel3(logic first, logic [2:0] idx);
    return first ? 3'h0 : idx + 1'b1;
  endfunction

  function automatic logic [1:0] rx_next(logic first, logic [2:0] idx);
    logic [2:0] n;
    n = rx_sel3(first, idx);
    return n[1:0];
  endfunction

  // last frame of a packet lands at the lowest bytes
  function automatic esp_block_t rx_merge(esp_block_t b, oh_pair_t o, logic f8, logic sel);
    esp_block_t m;
    m = b;
    if (!f8) begin
      m.hdr[31:0] = o.loc_a;
      m.trl[31:0] = o.loc_b;
    end else begin
      m.hdr[15:0] = sel ? o.loc_b[31:16] : o.loc_a[31:16];
      m.trl[15:0] = sel ? o.loc_b[15:0] : o.loc_a[15:0];
    end
    return m;
  endfunction

  // one independent session per trunk port
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_sess
    key_session u_sess (
      .core_clk(core_clk),
      .nrst(nrst),
      .auth_en(auth_en[g]),
      .restart(soft_reset),
      .rekey(rekey[g]),
      .trunk_ais(trunk_ais[g]),
      .pkt_boundary(tx_frame_start[g] && tx_idx[g] == '0),
      .kx_done(kx_done[g]),
      .kx_fail(kx_fail[g]),
      .kx_start(kx_start[g]),
      .authenticated(authenticated[g]),
      .alarm(key_exchange_failure_alarm[g]),
      .key_epoch(key_epoch[g])
    );
  end
endmodule

// ===== hw/otn_enc_consts.svh
// constants and contract of the encrypting otn port framer
// Contract
// - At most five ports in transponder mode
// - Operating mode held separately per port
// - No mode active until provisioned
// - Trunk wrapper follows client payload in transponder
// - Transponder trunk always carries otn framing
// - Regenerator repeats otu1e, otu2, otu2e both ways
// - Regenerator refuses authentication and encryption enables
// - Regenerator keeps otn framing permanently on
// - Authentication runs independently per trunk port
// - Encryption enable needs authentication enabled
// - Soft reset restarts authentication on all ports
// - Failed authentication raises alarm on that port
// - One primary key exchanged per session
// - Rekey on demand or periodically, hitless
// - No plaintext keys; reset erases key state
// - Each port ciphers payload independently, aes-256 xts
// - Encryption enabled at both trunk ends
// - Secure packet carries 32 esp bytes
// - Secure packet spans four or eight frames
// - Four-frame: two 4-byte locations per frame
// - Eight-frame: one location, two plus two bytes
// - Prbs test on chosen overhead bytes first
// - Key exchange waits for trunk ais clear
`ifndef OTN_ENC_CONSTS_SVH
`define OTN_ENC_CONSTS_SVH

`define NUM_PORT_PAIRS 5
`define MAX_TXP_PORTS 5
`define CLK_PERIOD_NS 40
`define REKEY_TICK_US 1000

`define REG_HI(a) a[7]
`define REG_PORT(a) a[6:4]
`define REG_SUB(a) a[3:2]
`define GLOBAL_PORT 3'h7
`define SUB_CFG 2'h0
`define SUB_STATUS 2'h1
`define SUB_CMD 2'h2
`define SUB_CARD_CTRL 2'h0
`define SUB_CARD_STATUS 2'h1
`define SUB_REKEY_PERIOD 2'h2

`define CFG_WIDTH 10
`define CFG_RESET 10'h000
`define MODE_ILLEGAL 2'h3
`define PAYLOAD_ILLEGAL 3'h7
`define CMD_REKEY_BIT 0
`define CTRL_SOFT_RESET_BIT 0
`define STAT_WIDTH 9
`define STAT_PRBS_ERR_BIT 4
`define STAT_REFUSED_BIT 8
`define TXP_CNT_W 4
`define PERIOD_W 16

`define FRAMES_SHORT 3'h3
`define FRAMES_LONG 3'h7
`define PRBS_SEED 32'hFFFFFFFF
`define PRBS_TAP_A 30
`define PRBS_TAP_B 27
`define PRBS_WORD 32

`endif

// ===== hw/otn_enc_pkg.sv
// types shared by the encrypting otn port framer
package otn_enc_pkg;
  typedef enum logic [1:0] {
    mode_off,
    single_stream_transponder_mode,
    regenerator_mode
  } port_mode_t;

  typedef enum logic [2:0] {
    pl_10ge_cbr,
    pl_otu2,
    pl_otu2e,
    pl_fc8,
    pl_fc10,
    pl_10ge_gfp,
    pl_otu1e
  } payload_t;

  typedef enum logic [1:0] {
    wrap_none,
    wrap_otu1e,
    wrap_otu2,
    wrap_otu2e
  } wrapper_t;

  typedef enum {
    ks_idle,
    ks_wait_ais,
    ks_exchange,
    ks_secure,
    ks_fail
  } session_state_t;

  typedef struct packed {
    logic oh_sel;
    logic prbs;
    logic frames8;
    logic enc;
    logic auth;
    payload_t payload;
    port_mode_t mode;
  } port_cfg_t;

  typedef struct packed {
    logic [31:0] loc_a;
    logic [31:0] loc_b;
  } oh_pair_t;

  typedef struct packed {
    logic [127:0] hdr;
    logic [127:0] trl;
  } esp_block_t;
endpackage

// ===== hw/key_session.sv
// per-port peer authentication and key epoch sequencer
`timescale 1ns/100ps
module key_session
  import otn_enc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic auth_en,
  input wire logic restart,
  input wire logic rekey,
  input wire logic trunk_ais,
  input wire logic pkt_boundary,
  // key exchange engine
  input wire logic kx_done,
  input wire logic kx_fail,
  output logic kx_start,
  // status
  output logic authenticated,
  output logic alarm,
  output logic key_epoch
);
  session_state_t state;
  logic staged;
  logic quiet;
  logic start_now;

  assign quiet = restart || !auth_en;
  assign start_now = !quiet && state == ks_wait_ais && !trunk_ais;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ks_idle;
    end else if (quiet) begin
      state <= auth_en ? ks_wait_ais : ks_idle;
    end else begin
      unique case (state)
        ks_idle: state <= ks_wait_ais;
        ks_wait_ais: if (!trunk_ais) state <= ks_exchange;
        ks_exchange: begin
          if (kx_done) state <= ks_secure;
          else if (kx_fail) state <= ks_fail;
        end
        ks_secure, ks_fail: if (rekey) state <= ks_wait_ais;
      endcase
    end
  end

  // one request per session or rekey
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) kx_start <= 1'b0;
    else kx_start <= start_now;
  end

  // derived keys wait for a packet boundary before going live
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      staged <= 1'b0;
      key_epoch <= 1'b0;
      authenticated <= 1'b0;
    end else if (quiet) begin
      staged <= 1'b0;
      key_epoch <= 1'b0;
      authenticated <= 1'b0;
    end else begin
      if (state == ks_exchange && kx_done) staged <= 1'b1;
      else if (pkt_boundary) staged <= 1'b0;
      if (pkt_boundary && staged) begin
        key_epoch <= ~key_epoch;
        authenticated <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) alarm <= 1'b0;
    else if (!auth_en) alarm <= 1'b0;
    else if (state == ks_exchange && kx_fail) alarm <= 1'b1;
    else if (state == ks_exchange && kx_done) alarm <= 1'b0;
  end
endmodule

// ===== tb/otn_enc_monitor.sv
// assertion checker for the encrypting otn port framer
`timescale 1ns/100ps
module otn_enc_monitor
  import otn_enc_pkg::*;
#(parameter int NUM_PORTS = 5) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // watched ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUM_PORTS-1:0] kx_start,
  input wire logic [NUM_PORTS-1:0] kx_fail,
  input wire logic [NUM_PORTS-1:0] trunk_ais,
  input wire logic [NUM_PORTS-1:0] tx_frame_start,
  input wire logic [NUM_PORTS-1:0] tx_pkt_start,
  input wire port_mode_t [NUM_PORTS-1:0] port_mode,
  input wire wrapper_t [NUM_PORTS-1:0] trunk_wrapper,
  input wire logic [NUM_PORTS-1:0] otn_enable,
  input wire logic [NUM_PORTS-1:0] cipher_enable,
  input wire logic [NUM_PORTS-1:0] key_exchange_failure_alarm
);
  logic [NUM_PORTS-1:0] on;
  logic [NUM_PORTS-1:0] txp;
  logic [NUM_PORTS-1:0] wrap_on;
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      on[i] = port_mode[i] != mode_off;
      txp[i] = port_mode[i] == single_stream_transponder_mode;
      wrap_on[i] = trunk_wrapper[i] != wrap_none;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_OTN_ON: assert property (otn_enable == on)
    else $error("otn framing off on a moded port");
  AST_OFF_NO_WRAP: assert property ((wrap_on & ~on) == '0)
    else $error("wrapper on an unmoded port");
  AST_CIPHER_TXP: assert property ((cipher_enable & ~txp) == '0)
    else $error("cipher outside transponder mode");
  AST_TXP_MAX: assert property ($countones(txp) <= 3'h5)
    else $error("too many transponder ports");
  AST_KX_PULSE: assert property (kx_start != '0 |=> (kx_start & $past(kx_start)) == '0)
    else $error("exchange start longer than one cycle");
  AST_KX_AIS: assert property ((kx_start & $past(trunk_ais)) == '0)
    else $error("exchange started during ais");
  AST_ALARM_CAUSE: assert property ((key_exchange_failure_alarm &
    ~$past(key_exchange_failure_alarm) & ~$past(kx_fail)) == '0)
    else $error("alarm without exchange failure");
  AST_PKT_START: assert property ((tx_pkt_start & ~$past(tx_frame_start)) == '0)
    else $error("packet start without frame start");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule
bind otn_port_encryption_framer otn_enc_monitor #(.NUM_PORTS(NUM_PORTS)) u_otn_enc_monitor (.*);

// ===== tb/kx_peer_model.sv
// key exchange engine standing for the peer card
`timescale 1ns/100ps
module kx_peer_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // requests and answer plan
  input wire logic [4:0] kx_start,
  input wire logic [4:0] fail_mask,
  input wire logic [4:0] slow_mask,
  // answers
  output logic [4:0] kx_done,
  output logic [4:0] kx_fail
);
  logic [5:0][4:0] pipe;
  logic [4:0] ans;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[4:0], kx_start};
    end
  end
  // one answer per request, fast or slow
  assign ans = (pipe[0] & ~slow_mask) | (pipe[5] & slow_mask);
  assign kx_done = ans & ~fail_mask;
  assign kx_fail = ans & fail_mask;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the encrypting otn port framer
`timescale 1ns/100ps
module testbench;
  import otn_enc_pkg::*;
  localparam logic [127:0] HDR = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] TRL = 128'hF0F1F2F3F4F5F6F7F8F9FAFBFCFDFEFF;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic [4:0] kx_done, kx_fail, kx_start, tx_pkt_start, rx_esp_valid;
  logic [4:0] otn_enable, cipher_enable, key_epoch, alarm, a_en, b_en;
  logic [4:0] trunk_ais = 5'h1F;
  logic [4:0] tx_frame_start = 5'h00;
  logic [4:0] rx_frame_start = 5'h00;
  logic [2:0] fcnt = 3'h0;
  esp_block_t [4:0] tx_esp;
  esp_block_t [4:0] rx_esp;
  oh_pair_t [4:0] tx_oh;
  port_mode_t [4:0] port_mode;
  wrapper_t [4:0] trunk_wrapper;
  wrapper_t exp_w [7] = '{wrap_otu2e, wrap_otu2, wrap_otu2e, wrap_otu2, wrap_otu2, wrap_otu2,
    wrap_otu1e};
  int err_count = 0;
  int n_compared = 0;
  assign tx_esp = {5{HDR, TRL}};
  initial forever #20 core_clk = ~core_clk;
  // frame every 8 cycles, trunk looped back
  always @(posedge core_clk) begin
    fcnt <= fcnt + 3'h1;
    tx_frame_start <= {5{fcnt == 3'h0}};
    rx_frame_start <= tx_frame_start;
  end
  otn_port_encryption_framer #(.TICK_CYCLES(4)) u_otn_port_encryption_framer (.core_clk, .nrst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .kx_done, .kx_fail, .kx_start,
    .trunk_ais, .tx_frame_start, .tx_esp, .tx_oh, .tx_oh_a_en(a_en), .tx_oh_b_en(b_en),
    .tx_pkt_start, .rx_frame_start, .rx_pkt_first(tx_pkt_start), .rx_oh(tx_oh), .rx_esp,
    .rx_esp_valid, .port_mode, .trunk_wrapper, .otn_enable, .cipher_enable, .key_epoch,
    .key_exchange_failure_alarm(alarm));
  kx_peer_model u_kx_peer_model (.core_clk, .nrst, .kx_start, .fail_mask(5'h02),
    .slow_mask(5'h04), .kx_done, .kx_fail);
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // sel: 0 packet start, 1 rx block, 2 epoch low, 3 cipher, 4 alarm
  task automatic wait_on(input int p, input int sel);
    logic [4:0] v;
    for (int i = 0; i < 400; i++) begin
      cyc(1);
      v = sel == 0 ? tx_pkt_start : sel == 1 ? rx_esp_valid : sel == 2 ? ~key_epoch :
        sel == 3 ? cipher_enable : alarm;
      if (v[p] === 1'b1) return;
    end
    err_count++;
    $display("BAD wait port %0d kind %0d expected 1 seen 0", p, sel);
    complete_run;
  endtask
  task automatic pkt(input int p, input logic f8);
    wait_on(p, 0);
    chk("oh_en", {1'b1, !f8}, {a_en[p], b_en[p]});
    if (f8) begin
      chk("loc_a", {HDR[127:112], TRL[127:112]}, tx_oh[p].loc_a);
      chk("loc_b", 32'h0, tx_oh[p].loc_b);
    end else begin
      chk("loc_a", HDR[127:96], tx_oh[p].loc_a);
      chk("loc_b", TRL[127:96], tx_oh[p].loc_b);
    end
    wait_on(p, 1);
    chk("rx_hdr", HDR, rx_esp[p].hdr);
    chk("rx_trl", TRL, rx_esp[p].trl);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h00);
    chk("cfg0", 32'h0, d);
    chk("mode", 10'h000, port_mode);
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, 32'h1 | (32'(i) << 2));
      cyc(2);
      chk("wrap", exp_w[i], trunk_wrapper[0]);
      chk("otn", 5'h01, otn_enable);
    end
    wr(8'h40, 32'h6);
    wr(8'h40, 32'h26);
    wr(8'h00, 32'h59);
    rd(8'h40);
    chk("cfg4", 32'h6, d);
    rd(8'h44);
    chk("refused4", 1'b1, d[8]);
    rd(8'h00);
    chk("cfg0", 32'h19, d);
    chk("mode4", regenerator_mode, port_mode[4]);
    chk("otn", 5'h11, otn_enable);
    wr(8'h10, 32'h21);
    wr(8'h20, 32'hE1);
    wr(8'h30, 32'h1);
    wr(8'h00, 32'h61);
    rd(8'h74);
    chk("txp_count", 32'h4, d);
    cyc(20);
    chk("cipher", 5'h00, cipher_enable);
    @(posedge core_clk);
    trunk_ais <= 5'h00;
    wait_on(0, 3);
    wait_on(1, 4);
    wait_on(2, 3);
    chk("alarm", 5'h02, alarm);
    chk("cipher", 5'h05, cipher_enable);
    rd(8'h04);
    chk("status0", 8'hCD, d[7:0]);
    pkt(0, 1'b0);
    pkt(2, 1'b1);
    wr(8'h08, 32'h1);
    wait_on(0, 2);
    chk("cipher", 5'h05, cipher_enable);
    wr(8'h70, 32'h1);
    cyc(4);
    chk("cipher", 5'h00, cipher_enable);
    wait_on(0, 3);
    rd(8'h00);
    chk("cfg0", 32'h61, d);
    // prbs on the overhead of port 3, looped back
    wr(8'h30, 32'h121);
    wait_on(3, 0);
    wait_on(3, 0);
    chk("oh_en3", 2'h3, {a_en[3], b_en[3]});
    rd(8'h34);
    chk("prbs_err", 1'b0, d[4]);
    wr(8'h78, 32'h3);
    rd(8'h78);
    chk("period", 32'h3, d);
    wait_on(0, 2);
    chk("cipher", 5'h05, cipher_enable);
    rd(8'h80);
    chk("unmapped", 32'h0, d);
    complete_run;
  end
endmodule
